//--- logic/ces_status_unit.sv
// Status saving registers, exception cause and program status word
`timescale 1ns/1ps
// Operation
// [RL1] Exception or maskable ack saves irq pair
// [RL2] NMI ack saves NMI pair only
// [RL3] Saved address is next instruction address
// [RL4] Irq pair upper bits always zero
// [RL5] NMI pair upper bits always zero
// [RL6] Return restores from irq pair
// [RL7] Return after NMI restores NMI pair
// [RL8] NMI active flag selects return pair
// [RL9] Record cause code; cause ignores writes
// [RL10] Status word write effective next instruction
// [RL11] Writing block flag stops ack meanwhile
// [RL12] Status word resets to 20h, upper zero
// [RL13] NMI ack sets flag, blocks nesting
// [RL14] Exception sets trap flag, acks continue
// [RL15] Block flag one masks maskable interrupts
// [RL16] Clamp flag sticky, cleared only by write; a return also restores it from the saved pair
// [RL17] Carry, overflow, negative follow last operation
// [RL18] Null flag marks zero result
// [RL19] Clamp flag set only with overflow
// [RL20] Positive overflow gives largest positive word
// [RL21] Negative overflow gives 80000000h
// [RL22] No overflow passes result, keeps clamp
// [RL23] Registers readable at slots zero to five
// [RL24] Maskable ack sets interrupt block flag
module ces_status_unit #(
	parameter int CODE_W = 16
) (
	input wire logic SYS_CLK, // CPU clock
	input wire logic RESET, // Synchronous reset
	input wire logic [31:0] NEXT_PC, // Address after current instruction
	input wire logic DEFER_ACK, // Current instruction defers acks
	input wire logic TRAP_REQ, // Software exception pulse
	input wire logic [CODE_W-1:0] TRAP_CODE, // Exception code
	input wire logic IRQ_REQ, // Maskable request level
	input wire logic [CODE_W-1:0] IRQ_CODE, // Maskable code
	input wire logic NMI_REQ, // Non-maskable request level
	input wire logic [CODE_W-1:0] NMI_CODE, // NMI code
	input wire logic RET_EXEC, // Return from interrupt pulse
	input wire logic SR_WE, // System register load
	input wire logic [4:0] SR_WNUM, // Load slot
	input wire logic [31:0] SR_WDATA, // Load data
	input wire logic [4:0] SR_RNUM, // Store slot
	input wire logic ALU_WE, // Arithmetic flag update
	input wire logic ALU_CY, // Carry or borrow
	input wire logic ALU_OV, // Overflow
	input wire logic ALU_NEG, // Negative result
	input wire logic ALU_ZERO, // Zero result
	input wire logic CLAMP_WE, // Saturating operation
	input wire logic CLAMP_CY, // Its carry
	input wire logic [32:0] CLAMP_SUM, // Its exact result
	output logic IRQ_ACK, // Maskable acknowledged
	output logic NMI_ACK, // NMI acknowledged
	output logic RESUME_VALID, // Return target valid
	output logic [31:0] RESUME_PC, // Return target
	output logic [31:0] SR_RDATA, // Store data
	output logic [31:0] CLAMP_RESULT, // Saturated result
	output logic [31:0] STATUS_WORD // Program status word
);
	if (CODE_W < 1 || CODE_W > 31)
	begin : g_bad_code_w
		$error("CODE_W must be 1 to 31");
	end

	ces_pkg::ces_stw_s stw_q, stw_d;
	logic [ces_pkg::PC_W-1:0] irq_pc_q, irq_pc_d, nmi_pc_q, nmi_pc_d;
	logic [ces_pkg::ST_W-1:0] irq_st_q, irq_st_d, nmi_st_q, nmi_st_d;
	logic [31:0] cause_q, cause_d;
	logic [31:0] rd_d;
	logic [31:0] clamp_res;
	logic clamp_ov, clamp_neg, clamp_zero;
	logic irq_ack_q, nmi_ack_q, ret_vld_q;
	logic [31:0] ret_pc_q, rd_q, clamp_res_q;
	ces_pkg::ces_evt_e evt;

	function automatic logic load_hit(input ces_pkg::ces_evt_e e, input logic [4:0] num,
		input logic [4:0] slot);
		return (e == ces_pkg::EV_LOAD) && (num == slot);
	endfunction

	function automatic logic [31:0] code_ext(input logic [CODE_W-1:0] code);
		return {{(32-CODE_W){1'b0}}, code};
	endfunction

	ces_clamp u_clamp (
		.sum(CLAMP_SUM),
		.result(clamp_res),
		.over(clamp_ov),
		.neg(clamp_neg),
		.zero(clamp_zero)
	);

	// A load that sets the block flag shuts out the maskable ack at once
	wire load_blocks = SR_WE && (SR_WNUM == ces_pkg::SLOT_STW) &&
		SR_WDATA[ces_pkg::POS_IRQ_BLOCK]; // [RL11]
	wire nmi_ok = NMI_REQ && !stw_q.nmi_active && !DEFER_ACK; // [RL13] [RL3]
	wire irq_ok = IRQ_REQ && !stw_q.irq_block && !stw_q.nmi_active && // [RL15] [RL13]
		!DEFER_ACK && !load_blocks; // [RL3] [RL11]
	wire trap_take = (evt == ces_pkg::EV_TRAP);
	wire irq_take = (evt == ces_pkg::EV_IRQ);
	wire nmi_take = (evt == ces_pkg::EV_NMI);
	wire ret_take = (evt == ces_pkg::EV_RET);

	// Trap flag is deliberately not a term of irq_ok
	assign evt = nmi_ok ? ces_pkg::EV_NMI : // [RL14]
		TRAP_REQ ? ces_pkg::EV_TRAP :
		irq_ok ? ces_pkg::EV_IRQ :
		RET_EXEC ? ces_pkg::EV_RET :
		SR_WE ? ces_pkg::EV_LOAD :
		(CLAMP_WE || ALU_WE) ? ces_pkg::EV_FLAGS :
		ces_pkg::EV_NONE;

	// Saved pairs keep only their valid bits, so the rest reads zero
	assign irq_pc_d = (trap_take || irq_take) ? NEXT_PC[ces_pkg::PC_W-1:0] : // [RL1] [RL3]
		load_hit(evt, SR_WNUM, ces_pkg::SLOT_IRQ_PC) ? SR_WDATA[ces_pkg::PC_W-1:0] :
		irq_pc_q; // [RL4]
	assign irq_st_d = (trap_take || irq_take) ? stw_q : // [RL1]
		load_hit(evt, SR_WNUM, ces_pkg::SLOT_IRQ_ST) ? SR_WDATA[ces_pkg::ST_W-1:0] :
		irq_st_q; // [RL4]
	assign nmi_pc_d = nmi_take ? NEXT_PC[ces_pkg::PC_W-1:0] : // [RL2] [RL3]
		load_hit(evt, SR_WNUM, ces_pkg::SLOT_NMI_PC) ? SR_WDATA[ces_pkg::PC_W-1:0] :
		nmi_pc_q; // [RL5]
	assign nmi_st_d = nmi_take ? stw_q : // [RL2]
		load_hit(evt, SR_WNUM, ces_pkg::SLOT_NMI_ST) ? SR_WDATA[ces_pkg::ST_W-1:0] :
		nmi_st_q; // [RL5]

	// Cause slot has no load path at all
	assign cause_d = nmi_take ? code_ext(NMI_CODE) : // [RL9]
		trap_take ? code_ext(TRAP_CODE) :
		irq_take ? code_ext(IRQ_CODE) :
		cause_q;

	always_comb
	begin
		stw_d = stw_q;
		unique case (evt)
			ces_pkg::EV_NMI:
			begin
				stw_d.nmi_active = 1'b1; // [RL13]
				stw_d.irq_block = 1'b1;
			end
			ces_pkg::EV_TRAP:
			begin
				stw_d.trap_active = 1'b1; // [RL14]
			end
			ces_pkg::EV_IRQ:
			begin
				stw_d.irq_block = 1'b1; // [RL24]
			end
			ces_pkg::EV_RET:
			begin
				stw_d = stw_q.nmi_active ? nmi_st_q : irq_st_q; // [RL6] [RL7] [RL8]
			end
			ces_pkg::EV_LOAD:
			begin
				if (SR_WNUM == ces_pkg::SLOT_STW)
				begin
					stw_d = SR_WDATA[ces_pkg::ST_W-1:0]; // [RL10] [RL16]
				end
			end
			ces_pkg::EV_FLAGS:
			begin
				if (CLAMP_WE)
				begin
					stw_d.carry = CLAMP_CY;
					stw_d.range_exceeded = clamp_ov; // [RL20] [RL21] [RL22]
					stw_d.negative = clamp_neg;
					stw_d.null_result = clamp_zero;
					stw_d.clamp_sticky = stw_q.clamp_sticky | clamp_ov; // [RL16] [RL19]
				end
				else
				begin
					stw_d.carry = ALU_CY; // [RL17]
					stw_d.range_exceeded = ALU_OV; // [RL17]
					stw_d.negative = ALU_NEG; // [RL17]
					stw_d.null_result = ALU_ZERO; // [RL18]
				end
			end
			ces_pkg::EV_NONE:
			begin
				stw_d = stw_q;
			end
		endcase
	end

	// Store path; reserved slots read as zero
	always_comb
	begin
		rd_d = 32'h00000000;
		case (SR_RNUM)
			ces_pkg::SLOT_IRQ_PC: rd_d = {6'h00, irq_pc_q}; // [RL23] [RL4]
			ces_pkg::SLOT_IRQ_ST: rd_d = {24'h000000, irq_st_q}; // [RL23] [RL4]
			ces_pkg::SLOT_NMI_PC: rd_d = {6'h00, nmi_pc_q}; // [RL23] [RL5]
			ces_pkg::SLOT_NMI_ST: rd_d = {24'h000000, nmi_st_q}; // [RL23] [RL5]
			ces_pkg::SLOT_CAUSE: rd_d = cause_q; // [RL23]
			ces_pkg::SLOT_STW: rd_d = {24'h000000, stw_q}; // [RL23] [RL12]
			default: rd_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			stw_q <= ces_pkg::STW_RESET; // [RL12]
			irq_pc_q <= '0;
			irq_st_q <= '0;
			nmi_pc_q <= '0;
			nmi_st_q <= '0;
			cause_q <= 32'h00000000;
		end
		else
		begin
			stw_q <= stw_d;
			irq_pc_q <= irq_pc_d;
			irq_st_q <= irq_st_d;
			nmi_pc_q <= nmi_pc_d;
			nmi_st_q <= nmi_st_d;
			cause_q <= cause_d;
		end
	end

	// Bit 0 of the target is dropped; code always lives on even addresses
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			irq_ack_q <= 1'b0;
			nmi_ack_q <= 1'b0;
			ret_vld_q <= 1'b0;
			ret_pc_q <= 32'h00000000;
			rd_q <= 32'h00000000;
			clamp_res_q <= 32'h00000000;
		end
		else
		begin
			irq_ack_q <= irq_take;
			nmi_ack_q <= nmi_take;
			ret_vld_q <= ret_take;
			if (ret_take)
			begin
				ret_pc_q <= stw_q.nmi_active ? {6'h00, nmi_pc_q[25:1], 1'b0} : // [RL7] [RL8]
					{6'h00, irq_pc_q[25:1], 1'b0}; // [RL6]
			end
			rd_q <= rd_d;
			if (CLAMP_WE)
			begin
				clamp_res_q <= clamp_res; // [RL20] [RL21] [RL22]
			end
		end
	end

	assign IRQ_ACK = irq_ack_q;
	assign NMI_ACK = nmi_ack_q;
	assign RESUME_VALID = ret_vld_q;
	assign RESUME_PC = ret_pc_q;
	assign SR_RDATA = rd_q;
	assign CLAMP_RESULT = clamp_res_q;
	assign STATUS_WORD = {24'h000000, stw_q};

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RESET);

	property p_irq_save;
		(trap_take || irq_take) |=>
			(irq_pc_q == $past(NEXT_PC[25:0])) && (irq_st_q == $past(stw_q));
	endproperty
	a_irq_save: assert property (p_irq_save) else $error("irq pair not saved"); // [RL1]

	property p_nmi_save;
		nmi_take |=> (nmi_pc_q == $past(NEXT_PC[25:0])) && (nmi_st_q == $past(stw_q)) &&
			(irq_pc_q == $past(irq_pc_q)) && (irq_st_q == $past(irq_st_q));
	endproperty
	a_nmi_save: assert property (p_nmi_save) else $error("nmi pair wrong"); // [RL2]

	property p_ret_nmi;
		(ret_take && stw_q.nmi_active) |=> RESUME_VALID && (stw_q == $past(nmi_st_q)) &&
			(RESUME_PC[25:1] == $past(nmi_pc_q[25:1])) && (RESUME_PC[31:26] == 6'h00);
	endproperty
	a_ret_nmi: assert property (p_ret_nmi) else $error("nmi return wrong"); // [RL7]

	property p_ret_irq;
		(ret_take && !stw_q.nmi_active) |=> RESUME_VALID &&
			(stw_q == $past(irq_st_q)) && (RESUME_PC[25:1] == $past(irq_pc_q[25:1]));
	endproperty
	a_ret_irq: assert property (p_ret_irq) else $error("irq return wrong"); // [RL6]

	property p_cause_ro;
		(evt == ces_pkg::EV_LOAD) |=> $stable(cause_q);
	endproperty
	a_cause_ro: assert property (p_cause_ro) else $error("cause was written"); // [RL9]

	property p_nmi_blocks;
		stw_q.nmi_active |=> !IRQ_ACK && !NMI_ACK;
	endproperty
	a_nmi_blocks: assert property (p_nmi_blocks) else $error("ack while nmi active"); // [RL13]

	property p_block_flag;
		(stw_q.irq_block || load_blocks) |=> !IRQ_ACK;
	endproperty
	a_block_flag: assert property (p_block_flag) else $error("masked ack taken"); // [RL15]

	property p_sticky;
		(stw_q.clamp_sticky && !ret_take && !(SR_WE && !nmi_ok && !TRAP_REQ && !irq_ok))
			|=> stw_q.clamp_sticky;
	endproperty
	a_sticky: assert property (p_sticky) else $error("clamp flag lost"); // [RL16]

	property p_clamp_pos;
		(CLAMP_WE && evt == ces_pkg::EV_FLAGS && !CLAMP_SUM[32] && CLAMP_SUM[31]) |=>
			(CLAMP_RESULT == 32'h7fffffff) && stw_q.clamp_sticky &&
			stw_q.range_exceeded && !stw_q.negative;
	endproperty
	a_clamp_pos: assert property (p_clamp_pos) else $error("positive clamp wrong"); // [RL20]

	property p_clamp_neg;
		(CLAMP_WE && evt == ces_pkg::EV_FLAGS && CLAMP_SUM[32] && !CLAMP_SUM[31]) |=>
			(CLAMP_RESULT == 32'h80000000) && stw_q.clamp_sticky &&
			stw_q.range_exceeded && stw_q.negative;
	endproperty
	a_clamp_neg: assert property (p_clamp_neg) else $error("negative clamp wrong"); // [RL21]

	// Sticky flag must survive an in-range saturating op
	property p_clamp_keep;
		(CLAMP_WE && evt == ces_pkg::EV_FLAGS && (CLAMP_SUM[32] == CLAMP_SUM[31])) |=>
			(CLAMP_RESULT == $past(CLAMP_SUM[31:0])) && !stw_q.range_exceeded &&
			(stw_q.negative == $past(CLAMP_SUM[31])) &&
			(stw_q.clamp_sticky == $past(stw_q.clamp_sticky));
	endproperty
	a_clamp_keep: assert property (p_clamp_keep) else $error("in-range clamp wrong"); // [RL22]

	property p_trap_flag;
		trap_take |=> stw_q.trap_active && (cause_q == $past(code_ext(TRAP_CODE)));
	endproperty
	a_trap_flag: assert property (p_trap_flag) else $error("trap flag not set"); // [RL14]

	property p_reset_value;
		RESET |=> (STATUS_WORD == 32'h00000020);
	endproperty
	a_reset_value: assert property (disable iff (1'b0) p_reset_value) // [RL12]
		else $error("status word reset wrong");

	property p_irq_sets_block;
		irq_take |=> IRQ_ACK && stw_q.irq_block && (cause_q == $past(code_ext(IRQ_CODE)));
	endproperty
	a_irq_sets_block: assert property (p_irq_sets_block) else $error("ack effects wrong"); // [RL24]

	property p_upper_zero;
		(SR_RNUM <= ces_pkg::SLOT_NMI_ST) |=> (SR_RDATA[31:26] == 6'h00);
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("reserved bits set"); // [RL4] [RL5]

endmodule // ces_status_unit

//--- common/ces_pkg.sv
// Shared constants and types for the CPU status and exception unit
package ces_pkg;

	// System register slot numbers
	localparam logic [4:0] SLOT_IRQ_PC = 5'h00;
	localparam logic [4:0] SLOT_IRQ_ST = 5'h01;
	localparam logic [4:0] SLOT_NMI_PC = 5'h02;
	localparam logic [4:0] SLOT_NMI_ST = 5'h03;
	localparam logic [4:0] SLOT_CAUSE = 5'h04;
	localparam logic [4:0] SLOT_STW = 5'h05;

	// Valid widths of saved program counter and saved status
	localparam int PC_W = 26;
	localparam int ST_W = 8;

	// Status word flag positions
	localparam int POS_NMI_ACTIVE = 7;
	localparam int POS_TRAP_ACTIVE = 6;
	localparam int POS_IRQ_BLOCK = 5;
	localparam int POS_CLAMP_STICKY = 4;
	localparam int POS_CARRY = 3;
	localparam int POS_RANGE = 2;
	localparam int POS_NEGATIVE = 1;
	localparam int POS_NULL = 0;

	// Status word reset value, low byte of 32'h00000020
	localparam logic [7:0] STW_RESET = 8'h20;

	// Clamped results of a saturating operation
	localparam logic [31:0] CLAMP_POS_MAX = 32'h7fffffff;
	localparam logic [31:0] CLAMP_NEG_MAX = 32'h80000000;

	typedef struct packed {
		logic nmi_active;
		logic trap_active;
		logic irq_block;
		logic clamp_sticky;
		logic carry;
		logic range_exceeded;
		logic negative;
		logic null_result;
	} ces_stw_s;

	// One action per cycle, in priority order
	typedef enum logic [2:0] {
		EV_NONE,
		EV_NMI,
		EV_TRAP,
		EV_IRQ,
		EV_RET,
		EV_LOAD,
		EV_FLAGS
	} ces_evt_e;

endpackage

//--- logic/ces_clamp.sv
// Saturation encoder for a 33-bit exact signed result
`timescale 1ns/1ps
module ces_clamp (
	input wire logic [32:0] sum, // Exact signed result
	output logic [31:0] result, // Clamped word
	output logic over, // Limit exceeded
	output logic neg, // Sign of clamped word
	output logic zero // Clamped word is zero
);
	// Sign bits disagree exactly when 32 bits cannot hold the value
	assign over = sum[32] ^ sum[31]; // [RL19]
	assign neg = over ? sum[32] : sum[31]; // [RL20] [RL21] [RL22]
	assign result = !over ? sum[31:0] : // [RL22]
		(sum[32] ? ces_pkg::CLAMP_NEG_MAX : ces_pkg::CLAMP_POS_MAX); // [RL20] [RL21]
	assign zero = (result == 32'h00000000);
endmodule // ces_clamp

//--- bench/ces_req_model.sv
// Request holder standing in for the interrupt controller
`timescale 1ns/1ps
module ces_req_model (
	input wire logic clk, // CPU clock
	input wire logic reset, // Synchronous reset
	input wire logic raise_irq, // Start maskable request
	input wire logic raise_nmi, // Start NMI request
	input wire logic irq_ack, // Maskable acknowledged
	input wire logic nmi_ack, // NMI acknowledged
	output logic irq_req, // Maskable level
	output logic nmi_req // NMI level
);
	// Levels stay up until acknowledged, so a refused request stays pending
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			irq_req <= 1'b0;
			nmi_req <= 1'b0;
		end
		else
		begin
			irq_req <= (irq_req & ~irq_ack) | raise_irq;
			nmi_req <= (nmi_req & ~nmi_ack) | raise_nmi;
		end
	end
endmodule // ces_req_model

//--- bench/testbench.sv
// Self-checking bench for the status and exception unit
`timescale 1ns/1ps
module testbench;
	logic SYS_CLK, RESET, defer, trap, ret, we, awe, ay, ao, an, az, cwe, ccy;
	logic r_irq, r_nmi, irq_req, nmi_req, irq_ack, nmi_ack, rv;
	logic [31:0] npc, wdata, rpc, rdata, cres, sw;
	logic [15:0] tcode;
	logic [4:0] wnum, rnum;
	logic [32:0] csum;
	int fails = 0;
	int n_tests = 0;
	int cyc = 0;
	ces_status_unit #(.CODE_W(16)) dut (.SYS_CLK(SYS_CLK), .RESET(RESET), .NEXT_PC(npc),
		.DEFER_ACK(defer), .TRAP_REQ(trap), .TRAP_CODE(tcode), .IRQ_REQ(irq_req),
		.IRQ_CODE(16'h0011), .NMI_REQ(nmi_req), .NMI_CODE(16'h0022), .RET_EXEC(ret),
		.SR_WE(we), .SR_WNUM(wnum), .SR_WDATA(wdata), .SR_RNUM(rnum), .ALU_WE(awe),
		.ALU_CY(ay), .ALU_OV(ao), .ALU_NEG(an), .ALU_ZERO(az), .CLAMP_WE(cwe),
		.CLAMP_CY(ccy), .CLAMP_SUM(csum), .IRQ_ACK(irq_ack), .NMI_ACK(nmi_ack),
		.RESUME_VALID(rv), .RESUME_PC(rpc), .SR_RDATA(rdata), .CLAMP_RESULT(cres),
		.STATUS_WORD(sw));
	ces_req_model far (.clk(SYS_CLK), .reset(RESET), .raise_irq(r_irq), .raise_nmi(r_nmi),
		.irq_ack(irq_ack), .nmi_ack(nmi_ack), .irq_req(irq_req), .nmi_req(nmi_req));
	task close_out;
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task rd(input logic [4:0] s, input logic [31:0] e);
		@(posedge SYS_CLK);
		rnum <= s;
		@(posedge SYS_CLK);
		#1;
		chk(rdata, e);
	endtask
	task load(input logic [4:0] s, input logic [31:0] d);
		@(posedge SYS_CLK);
		we <= 1'b1;
		wnum <= s;
		wdata <= d;
		@(posedge SYS_CLK);
		we <= 1'b0;
		#1;
	endtask
	task raise(input logic nmi);
		@(posedge SYS_CLK);
		if (nmi)
			r_nmi <= 1'b1;
		else
			r_irq <= 1'b1;
		@(posedge SYS_CLK);
		r_nmi <= 1'b0;
		r_irq <= 1'b0;
	endtask
	// Bounded wait; ack pulse is one cycle so it is seen where it stands
	task wait_ack(input logic [1:0] e);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge SYS_CLK);
			#1;
			if ((irq_ack | nmi_ack) === 1'b1)
				break;
		end
		chk({nmi_ack, irq_ack}, e);
	endtask
	task quiet;
		repeat (4)
		begin
			@(posedge SYS_CLK);
			#1;
			chk({nmi_ack, irq_ack}, 2'h0);
		end
	endtask
	task ret_op(input logic [31:0] epc, input logic [31:0] esw);
		@(posedge SYS_CLK);
		ret <= 1'b1;
		@(posedge SYS_CLK);
		ret <= 1'b0;
		#1;
		chk(rv, 32'h00000001);
		chk(rpc, epc);
		chk(sw, esw);
	endtask
	task clamp(input logic [32:0] s, input logic [31:0] er, input logic [31:0] esw);
		@(posedge SYS_CLK);
		cwe <= 1'b1;
		csum <= s;
		ccy <= s[32];
		@(posedge SYS_CLK);
		cwe <= 1'b0;
		#1;
		chk(cres, er);
		chk(sw, esw);
	endtask
	task alu(input logic [3:0] f, input logic [31:0] esw);
		@(posedge SYS_CLK);
		awe <= 1'b1;
		{ay, ao, an, az} <= f;
		@(posedge SYS_CLK);
		awe <= 1'b0;
		#1;
		chk(sw, esw);
	endtask
	initial
	begin
		SYS_CLK = 1'b0;
		forever #2 SYS_CLK = ~SYS_CLK;
	end
	always @(posedge SYS_CLK)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			close_out();
		end
	end
	initial
	begin
		{RESET, defer, trap, ret, we, awe, ay, ao, an, az, cwe, ccy, r_irq, r_nmi} = 14'h2000;
		npc = 32'hfc001234;
		wdata = 32'h0;
		tcode = 16'h0005;
		wnum = 5'h00;
		rnum = 5'h00;
		csum = 33'h0;
		repeat (3) @(posedge SYS_CLK);
		RESET <= 1'b0;
		@(posedge SYS_CLK);
		#1;
		chk(sw, 32'h00000020);
		rd(5'h04, 32'h0);
		raise(1'b0);
		quiet();
		load(5'h05, 32'hffffff00);
		chk(sw, 32'h00000000);
		wait_ack(2'h1);
		chk(sw, 32'h00000020);
		rd(5'h00, 32'h00001234);
		rd(5'h01, 32'h00000000);
		rd(5'h04, 32'h00000011);
		@(posedge SYS_CLK);
		trap <= 1'b1;
		@(posedge SYS_CLK);
		trap <= 1'b0;
		#1;
		chk(sw, 32'h00000060);
		rd(5'h01, 32'h00000020);
		load(5'h04, 32'hffffffff);
		rd(5'h04, 32'h00000005);
		rd(5'h07, 32'h0);
		@(posedge SYS_CLK);
		npc <= 32'h00002000;
		defer <= 1'b1;
		raise(1'b1);
		quiet();
		@(posedge SYS_CLK);
		defer <= 1'b0;
		wait_ack(2'h2);
		chk(sw, 32'h000000e0);
		rd(5'h04, 32'h00000022);
		rd(5'h02, 32'h00002000);
		rd(5'h03, 32'h00000060);
		rd(5'h00, 32'h00001234);
		ret_op(32'h00002000, 32'h00000060);
		ret_op(32'h00001234, 32'h00000020);
		clamp(33'h080000000, 32'h7fffffff, 32'h00000034);
		clamp(33'h17fffffff, 32'h80000000, 32'h0000003e);
		clamp(33'h000000005, 32'h00000005, 32'h00000030);
		alu(4'h1, 32'h00000031);
		alu(4'he, 32'h0000003e);
		load(5'h05, 32'h00000000);
		chk(sw, 32'h00000000);
		// Block flag written while a request arrives must hold off the ack
		@(posedge SYS_CLK);
		r_irq <= 1'b1;
		@(posedge SYS_CLK);
		r_irq <= 1'b0;
		we <= 1'b1;
		wnum <= 5'h05;
		wdata <= 32'h00000020;
		@(posedge SYS_CLK);
		we <= 1'b0;
		#1;
		chk({nmi_ack, irq_ack}, 32'h00000000);
		quiet();
		chk(sw, 32'h00000020);
		close_out();
	end
endmodule // testbench
